// ===== design/rxf_host.sv
// Purpose: Receive FIFO with per-byte error status, fill/idle request and flush control
// Assumes: Classic Wishbone slave, one clock, pump inputs synchronous to sys_clk
// Notes:   bit_tick is a one-cycle pulse per line bit time from the data pump
//
// Overview of operation
// - Trigger bit 1 clear: buffer-full request comes only from fill threshold
// - Sync flag bit in register 0A bit 1 reports 7E flag, HDLC only
// - Break-detected bit in register 0E bit 6 reports received async break
// - Register 0A bit 4: framing error async, abort in HDLC
// - Register 0A bit 5: parity error async, CRC failure in HDLC
// - Register 01 bit 0 shows received parity bit in stuff-parity mode
// - Register 01 bit 1 set while FIFO holds at least half capacity
// - Register 0C bit 1 set while FIFO holds any data
// - Writing one to 031 bit 7 empties receive FIFO, bit 3 transmit FIFO
// - Trigger bits 7:6 pick threshold 1, 4, 8 or 14 bytes
// - Trigger bits 4:2 pick idle time-out 9 to 37 bit times
// - Idle interval restarts on every pump write, receive-data pop or receive flush
// - Trigger register resets to CBh
`timescale 1ns/1ps
module rxf_host
  import rxf_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Data pump side
  input  wire logic        pump_valid,
  output logic             pump_ready,
  input  wire logic [7:0]  pump_data,
  input  wire logic        pump_break,
  input  wire logic        pump_sync,
  input  wire logic        pump_frame_err,
  input  wire logic        pump_parity_err,
  input  wire logic        pump_parity_bit,
  input  wire logic        bit_tick,
  // Host-facing status and control
  output logic             rx_buffer_full_req,
  output logic             rx_half_full,
  output logic             rx_not_empty,
  output logic             tx_flush,
  output logic             irq
);

  localparam int AW = $clog2(DEPTH);

  // Pointer arithmetic relies on a power-of-two depth; refused while elaborating
  if (DEPTH < 16 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("rxf_host: DEPTH must be a power of two from 16 to 64");
  end

  typedef struct packed {
    logic [DEPTH-1:0][ENT_W-1:0] mem;
    logic [AW-1:0]               rd_ptr;
    logic [AW-1:0]               wr_ptr;
    logic [AW:0]                 count;
    logic [7:0]                  trig;
    logic                        hdlc;
    logic [IRQ_W-1:0]            irq_stat;
    logic [IRQ_W-1:0]            irq_mask;
    logic [5:0]                  idle_cnt;
    logic                        timed_out;
    logic                        ack;
    logic [31:0]                 dat;
    logic                        tx_flush;
    logic [IRQ_W-1:0]            ev_q;
  } rxf_state_t;

  rxf_state_t s;
  rxf_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Fill threshold from trigger bits 7:6
  function automatic logic [4:0] rxf_thresh(input logic [1:0] code);
    case (code)
      2'b00:   return THRESH_0;
      2'b01:   return THRESH_1;
      2'b10:   return THRESH_2;
      default: return THRESH_3;
    endcase
  endfunction : rxf_thresh

  // Idle limit in bit times from trigger bits 4:2
  function automatic logic [5:0] rxf_idle_limit(input logic [2:0] code);
    return IDLE_BASE_BITS + 6'(IDLE_STEP_BITS * code);
  endfunction : rxf_idle_limit

  // Register word hit
  function automatic logic rxf_hit(input logic [11:0] adr, input logic [9:0] idx);
    return adr[11:2] == idx;
  endfunction : rxf_hit

  ////////////////////////////////////////////////////////////////////////////////
  // Combinational view of the FIFO head and flags

  logic [ENT_W-1:0] head;
  logic             not_empty;
  logic             half_full;
  logic             full;
  logic [4:0]       thresh;
  logic             fill_req;
  logic             bus_req;
  logic             bus_take;
  logic             host_pop;
  logic             rx_flush_cmd;
  logic             push;
  logic             pop;
  logic [31:0]      rd_val;

  // Head entry is only meaningful when not empty, so flags are gated by it
  assign head      = s.mem[s.rd_ptr] & {ENT_W{not_empty}};
  assign not_empty = s.count != '0;
  assign half_full = s.count >= (AW + 1)'(DEPTH / 2);
  assign full      = s.count == (AW + 1)'(DEPTH);
  assign thresh    = rxf_thresh(s.trig[TRIG_LVL_LSB +: 2]);
  assign fill_req  = s.count >= (AW + 1)'(thresh);

  // Time-out path only counts when enabled, and never on an empty FIFO
  assign rx_buffer_full_req = fill_req
                            | (s.trig[TRIG_TO_EN] & s.timed_out & not_empty);
  assign rx_half_full = half_full;
  assign rx_not_empty = not_empty;
  assign tx_flush     = s.tx_flush;
  assign irq          = |(s.irq_stat & s.irq_mask);
  assign wb_ack_o     = s.ack;
  assign wb_dat_o     = s.dat;

  // Pump back-pressure: a full FIFO refuses the byte until the host drains one
  assign pump_ready = !full;

  // Bus request seen in first cycle; write and pop act at the edge ack is sampled
  assign bus_req      = wb_cyc_i & wb_stb_i & !s.ack;
  assign bus_take     = wb_cyc_i & wb_stb_i & s.ack;
  assign host_pop     = bus_take & !wb_we_i & rxf_hit(wb_adr_i, REG_RX_DATA) & not_empty;
  assign rx_flush_cmd = bus_take & wb_we_i & wb_sel_i[0] & rxf_hit(wb_adr_i, REG_FLUSH)
                      & wb_dat_i[BIT_RX_FLUSH];
  assign push         = pump_valid & !full & !rx_flush_cmd;
  assign pop          = host_pop & !rx_flush_cmd;

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; status registers are read before the data pop

  always_comb begin
    rd_val = 32'h0000_0000;
    case (wb_adr_i[11:2])
      REG_RX_DATA: rd_val[7:0] = head[7:0];
      REG_STAT_01: begin
        rd_val[BIT_PARITY_RX] = !s.hdlc & head[ENT_PAR];
        rd_val[BIT_HALF_FULL] = half_full;
      end
      REG_STAT_0A: begin
        rd_val[BIT_SYNC_FLAG]  = s.hdlc & head[ENT_SYN];
        rd_val[BIT_FRAME_ERR]  = head[ENT_FE];
        rd_val[BIT_PARITY_ERR] = head[ENT_PE];
      end
      REG_STAT_0C:  rd_val[BIT_NOT_EMPTY] = not_empty;
      REG_STAT_0E:  rd_val[BIT_BREAK]     = head[ENT_BRK];
      REG_TRIGGER:  rd_val[7:0]           = s.trig;
      REG_IRQ_STAT: rd_val[IRQ_W-1:0]     = s.irq_stat;
      REG_IRQ_MASK: rd_val[IRQ_W-1:0]     = s.irq_mask;
      REG_MODE:     rd_val[BIT_HDLC_MODE] = s.hdlc;
      default:      rd_val = 32'h0000_0000;  // Flush bits self-clear; unmapped reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic [IRQ_W-1:0] ev_now;
  logic [IRQ_W-1:0] ev_rise;
  logic [IRQ_W-1:0] w1c;

  always_comb begin
    next_s = s;
    ev_now = '0;
    ev_rise = '0;
    w1c = '0;

    // Bus handshake: ack one cycle after the request, dropped the cycle after
    next_s.ack = bus_req;
    if (bus_req) begin
      next_s.dat = rd_val;
    end
    next_s.tx_flush = 1'b0;

    // FIFO storage; status bits ride with the byte
    if (push) begin
      next_s.mem[s.wr_ptr] = {pump_parity_bit, pump_parity_err, pump_frame_err,
                              pump_sync, pump_break, pump_data};
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   next_s.count = s.count + 1'b1;
      2'b01:   next_s.count = s.count - 1'b1;
      default: next_s.count = s.count;
    endcase
    if (rx_flush_cmd) begin
      next_s.rd_ptr = '0;
      next_s.wr_ptr = '0;
      next_s.count  = '0;
    end

    // Idle timer: restarted by traffic, counts bit ticks up to the chosen limit
    if (push || pop || rx_flush_cmd) begin
      next_s.idle_cnt  = '0;
      next_s.timed_out = 1'b0;
    end else if (bit_tick && !s.timed_out) begin
      if (s.idle_cnt + 6'd1 >= rxf_idle_limit(s.trig[TRIG_TO_LSB +: 3])) begin
        next_s.timed_out = 1'b1;
        next_s.idle_cnt  = '0;
      end else begin
        next_s.idle_cnt = s.idle_cnt + 6'd1;
      end
    end

    // Register writes take effect at the edge where ack is sampled
    if (bus_take && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i[11:2])
        REG_FLUSH:    next_s.tx_flush = wb_dat_i[BIT_TX_FLUSH];
        REG_TRIGGER:  next_s.trig     = wb_dat_i[7:0] & TRIG_WMASK;
        REG_IRQ_STAT: w1c             = wb_dat_i[IRQ_W-1:0];
        REG_IRQ_MASK: next_s.irq_mask = wb_dat_i[IRQ_W-1:0];
        REG_MODE:     next_s.hdlc     = wb_dat_i[BIT_HDLC_MODE];
        default:      next_s.trig     = s.trig;
      endcase
    end

    // Sticky events on rising flags; a new event wins over a same-cycle clear
    ev_now[IRQ_BUF_FULL]  = rx_buffer_full_req;
    ev_now[IRQ_NOT_EMPTY] = not_empty;
    ev_now[IRQ_HALF_FULL] = half_full;
    ev_rise = ev_now & ~s.ev_q;
    next_s.ev_q = ev_now;
    next_s.irq_stat = (s.irq_stat & ~w1c) | ev_rise;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s      <= '0;
      s.trig <= TRIG_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic rd_0a;
  logic rd_01;
  logic rd_0e;
  assign rd_0a = s.ack & !wb_we_i & rxf_hit(wb_adr_i, REG_STAT_0A);
  assign rd_01 = s.ack & !wb_we_i & rxf_hit(wb_adr_i, REG_STAT_01);
  assign rd_0e = s.ack & !wb_we_i & rxf_hit(wb_adr_i, REG_STAT_0E);

  AST_TO_OFF_THRESH_ONLY: assert property (
    !s.trig[TRIG_TO_EN] && rx_buffer_full_req |-> s.count >= (AW + 1)'(thresh))
    else $error("Buffer-full raised below threshold with time-out off");

  AST_SYNC_HDLC_ONLY: assert property (
    rd_0a |-> wb_dat_o[BIT_SYNC_FLAG] == $past(s.hdlc & head[ENT_SYN]))
    else $error("Sync flag read does not match head byte in HDLC mode");

  AST_BREAK_HEAD: assert property (
    rd_0e |-> wb_dat_o[BIT_BREAK] == $past(head[ENT_BRK]))
    else $error("Break bit does not describe head byte");

  AST_FRAME_HEAD: assert property (
    rd_0a |-> wb_dat_o[BIT_FRAME_ERR] == $past(head[ENT_FE]))
    else $error("Frame/abort bit does not describe head byte");

  AST_PARITY_HEAD: assert property (
    rd_0a |-> wb_dat_o[BIT_PARITY_ERR] == $past(head[ENT_PE]))
    else $error("Parity/CRC bit does not describe head byte");

  AST_RX_PARITY: assert property (
    rd_01 |-> wb_dat_o[BIT_PARITY_RX] == $past(!s.hdlc & head[ENT_PAR]))
    else $error("Received parity bit mismatch");

  AST_HALF_RISE: assert property (
    push && !pop && s.count == (AW + 1)'(DEPTH / 2 - 1) |=> rx_half_full)
    else $error("Half-full not set on reaching half capacity");

  AST_EMPTY_AFTER_FLUSH: assert property (
    rx_flush_cmd |=> !rx_not_empty && s.count == '0)
    else $error("Receive flush did not empty the FIFO");

  AST_TX_FLUSH: assert property (
    bus_take && wb_we_i && wb_sel_i[0] && rxf_hit(wb_adr_i, REG_FLUSH)
      && wb_dat_i[BIT_TX_FLUSH] |=> tx_flush ##1 !tx_flush)
    else $error("Transmit flush pulse missing or too long");

  AST_THRESH_REQ: assert property (
    s.count >= (AW + 1)'(thresh) |-> rx_buffer_full_req)
    else $error("Threshold reached without buffer-full request");

  AST_IDLE_EXPIRE: assert property (
    bit_tick && !s.timed_out && !push && !pop && !rx_flush_cmd
      && s.idle_cnt == rxf_idle_limit(s.trig[TRIG_TO_LSB +: 3]) - 6'd1
      |=> s.timed_out)
    else $error("Idle time-out did not expire at its limit");

  AST_IDLE_RESTART: assert property (
    push || pop |=> s.idle_cnt == '0 && !s.timed_out)
    else $error("Idle interval not restarted by traffic");

  AST_TRIG_RESET: assert property (
    $fell(rst) |-> s.trig == TRIG_RESET)
    else $error("Trigger register not CBh after reset");

  AST_NOT_EMPTY_ON_PUSH: assert property (
    push |=> rx_not_empty)
    else $error("Not-empty flag missing after a byte was stored");

  AST_HALF_FALL: assert property (
    pop && !push && s.count == (AW + 1)'(DEPTH / 2) |=> !rx_half_full)
    else $error("Half-full still set below half capacity");

  AST_NO_REQ_WHEN_EMPTY: assert property (
    !rx_not_empty |-> !rx_buffer_full_req)
    else $error("Buffer-full request raised on an empty FIFO");

endmodule : rxf_host

// ===== design/rxf_pkg.sv
// Purpose: Shared constants for the receive FIFO host interface
// Assumes: Word index of a register is its printed offset; byte address is four times it
// Notes:   FIFO entry packs the byte with its five error/status flags
package rxf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register word indices (byte address = index * 4)
  localparam logic [9:0] REG_RX_DATA  = 10'h000;
  localparam logic [9:0] REG_STAT_01  = 10'h001;
  localparam logic [9:0] REG_STAT_0A  = 10'h00a;
  localparam logic [9:0] REG_STAT_0C  = 10'h00c;
  localparam logic [9:0] REG_STAT_0E  = 10'h00e;
  localparam logic [9:0] REG_FLUSH    = 10'h031;
  localparam logic [9:0] REG_TRIGGER  = 10'h32c;
  localparam logic [9:0] REG_IRQ_STAT = 10'h040;
  localparam logic [9:0] REG_IRQ_MASK = 10'h041;
  localparam logic [9:0] REG_MODE     = 10'h042;

  ////////////////////////////////////////////////////////////////////////////////
  // Status bit positions within their registers
  localparam int BIT_PARITY_RX  = 0;   // Register 01
  localparam int BIT_HALF_FULL  = 1;   // Register 01
  localparam int BIT_SYNC_FLAG  = 1;   // Register 0A
  localparam int BIT_FRAME_ERR  = 4;   // Register 0A
  localparam int BIT_PARITY_ERR = 5;   // Register 0A
  localparam int BIT_NOT_EMPTY  = 1;   // Register 0C
  localparam int BIT_BREAK      = 6;   // Register 0E
  localparam int BIT_RX_FLUSH   = 7;   // Flush control
  localparam int BIT_TX_FLUSH   = 3;   // Flush control
  localparam int BIT_HDLC_MODE  = 0;   // Mode register

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger register layout and reset value
  localparam logic [7:0] TRIG_RESET   = 8'hcb;
  localparam logic [7:0] TRIG_WMASK   = 8'hde;  // Bits 5 and 0 read zero after any write; reset value CBh leaves bit 0 set
  localparam int         TRIG_LVL_LSB = 6;
  localparam int         TRIG_TO_LSB  = 2;
  localparam int         TRIG_TO_EN   = 1;

  // Threshold and idle time-out figures
  localparam logic [4:0] THRESH_0 = 5'd1;
  localparam logic [4:0] THRESH_1 = 5'd4;
  localparam logic [4:0] THRESH_2 = 5'd8;
  localparam logic [4:0] THRESH_3 = 5'd14;
  localparam logic [5:0] IDLE_BASE_BITS = 6'd9;
  localparam logic [5:0] IDLE_STEP_BITS = 6'd4;

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO entry layout
  localparam int ENT_BRK = 8;
  localparam int ENT_SYN = 9;
  localparam int ENT_FE  = 10;
  localparam int ENT_PE  = 11;
  localparam int ENT_PAR = 12;
  localparam int ENT_W   = 13;

  // Interrupt status bits
  localparam int IRQ_BUF_FULL  = 0;
  localparam int IRQ_NOT_EMPTY = 1;
  localparam int IRQ_HALF_FULL = 2;
  localparam int IRQ_W         = 3;

endpackage : rxf_pkg

// ===== dv/rxf_host_tb.sv
// Purpose: Self-checking bench for the receive FIFO host interface
// Assumes: Wishbone answers in its own time; pump model feeds bytes
// Notes:   Tick counter mirrors the idle timer restart on every push
`timescale 1ns/1ps
module rxf_host_tb;
  import rxf_pkg::*;
  localparam logic [9:0] STATS [4] = '{REG_STAT_01, REG_STAT_0A, REG_STAT_0C, REG_STAT_0E};
  localparam int         THR   [4] = '{1, 4, 8, 14};
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        send = 1'b0;
  logic [12:0] entry = 13'h0000;
  logic        hdlc = 1'b0;
  logic [31:0] wb_dat_o;
  logic [12:0] pump_word;
  logic [12:0] q [$];
  logic [7:0]  rd;
  logic        wb_ack_o, pump_valid, pump_ready, bit_tick, busy;
  logic        req, half, nempty, tx_flush, irq;
  int          mismatches = 0, checks = 0, cycles = 0, ticks = 0, txp = 0;

  always #12.5 sys_clk = ~sys_clk;

  rxf_host #(.DEPTH(16)) i_rxf_host (.sys_clk(sys_clk), .rst(rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pump_valid(pump_valid),
    .pump_ready(pump_ready), .pump_data(pump_word[7:0]), .pump_break(pump_word[ENT_BRK]),
    .pump_sync(pump_word[ENT_SYN]), .pump_frame_err(pump_word[ENT_FE]),
    .pump_parity_err(pump_word[ENT_PE]), .pump_parity_bit(pump_word[ENT_PAR]),
    .bit_tick(bit_tick), .rx_buffer_full_req(req), .rx_half_full(half),
    .rx_not_empty(nempty), .tx_flush(tx_flush), .irq(irq));
  rxf_pump_model i_rxf_pump_model (.sys_clk(sys_clk), .rst(rst), .send(send), .entry(entry),
    .busy(busy), .pump_ready(pump_ready), .pump_valid(pump_valid), .pump_word(pump_word),
    .bit_tick(bit_tick));

  ////////////////////////////////////////
  // Idle tick mirror, tx flush pulse count and hang limit
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    ticks  <= (pump_valid && pump_ready) ? 0 : ticks + int'(bit_tick);
    txp    <= txp + int'(tx_flush === 1'b1);
    if (cycles == 30000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic cmp1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp1

  // Classic cycle: request held until ack is sampled, then released
  task automatic wb(input logic [9:0] idx, input logic we, input logic [7:0] d);
    @(posedge sys_clk);
    wb_adr_i <= {idx, 2'b00};
    wb_we_i  <= we;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'h1;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // Let the edge pass so that what the write or pop changed has settled
    @(posedge sys_clk);
  endtask : wb

  task automatic push(input logic [12:0] e);
    @(posedge sys_clk);
    send  <= 1'b1;
    entry <= e;
    @(posedge sys_clk);
    send <= 1'b0;
    do @(posedge sys_clk); while (busy !== 1'b0);
    q.push_back(e);
  endtask : push

  task automatic flush();
    wb(REG_FLUSH, 1'b1, 8'h80);
    q.delete();
  endtask : flush

  // Status of the head byte as the host should see it
  function automatic logic [7:0] exp_stat(input logic [9:0] idx, input logic [12:0] e,
                                          input int n, input logic h);
    case (idx)
      REG_STAT_01: return {6'h00, n >= 8, ~h & e[ENT_PAR]};
      REG_STAT_0A: return {2'b00, e[ENT_PE], e[ENT_FE], 2'b00, h & e[ENT_SYN], 1'b0};
      REG_STAT_0C: return {6'h00, n != 0, 1'b0};
      default:     return {1'b0, e[ENT_BRK], 6'h00};
    endcase
  endfunction : exp_stat

  // Status first, then the byte, as the host must do it
  task automatic pop_check();
    logic [12:0] e;
    logic [7:0]  x;
    e = q[0];
    foreach (STATS[i]) begin
      wb(STATS[i], 1'b0, 8'h00);
      x = exp_stat(STATS[i], e, q.size(), hdlc);
      cmp8("status", x, rd);
    end
    wb(REG_RX_DATA, 1'b0, 8'h00);
    cmp8("rx data", e[7:0], rd);
    void'(q.pop_front());
  endtask : pop_check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////
  // Main sequence
  initial begin
    int code;
    void'($urandom(86132));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    wb(REG_TRIGGER, 1'b0, 8'h00);
    cmp8("trigger reset", TRIG_RESET, rd);
    wb(10'h3ff, 1'b0, 8'h00);
    cmp8("unmapped read", 8'h00, rd);
    $display("test reset done");
    for (int i = 1; i <= 16; i++) begin
      push(13'($urandom()));
      cmp1("half full", i >= 8, half);
      cmp1("fill request", i >= 14, req);
      cmp1("not empty", 1'b1, nempty);
    end
    cmp1("ready when full", 1'b0, pump_ready);
    while (q.size() > 0) pop_check();
    cmp1("empty after drain", 1'b0, nempty);
    wb(REG_MODE, 1'b1, 8'h01);
    hdlc = 1'b1;
    push(13'h1fa5);
    repeat (4) push(13'($urandom()));
    while (q.size() > 0) pop_check();
    wb(REG_MODE, 1'b1, 8'h00);
    hdlc = 1'b0;
    $display("test fill, drain and modes done");
    // Each threshold with the idle time-out off
    foreach (THR[c]) begin
      wb(REG_TRIGGER, 1'b1, {2'(c), 6'h00});
      for (int i = 1; i <= 15; i++) begin
        push(13'($urandom()));
        cmp1("threshold request", i >= THR[c], req);
        if (c == 3 && i == 13) begin
          repeat (200) @(posedge sys_clk);
          cmp1("no idle request", 1'b0, req);
        end
      end
      flush();
      cmp1("rx flushed", 1'b0, nempty);
    end
    wb(REG_RX_DATA, 1'b0, 8'h00);
    cmp8("read when empty", 8'h00, rd);
    // Idle time-out length, and its restart on a fresh byte
    for (int k = 0; k < 3; k++) begin
      code = (k == 0) ? 0 : (k == 1) ? 7 : int'($urandom_range(1, 6));
      wb(REG_TRIGGER, 1'b1, {2'b11, 1'b0, 3'(code), 2'b10});
      push(13'($urandom()));
      if (k == 2) begin
        while (ticks < 5) @(posedge sys_clk);
        push(13'($urandom()));
      end
      do @(posedge sys_clk); while (req !== 1'b1 && ticks < 60);
      cmp8("idle ticks", 8'(9 + 4 * code), 8'(ticks));
      flush();
    end
    $display("test thresholds and idle done");
    // Transmit flush leaves receive data alone; interrupt mask and clear
    wb(REG_TRIGGER, 1'b1, 8'hc0);
    push(13'($urandom()));
    wb(REG_FLUSH, 1'b1, 8'h08);
    repeat (2) @(posedge sys_clk);
    cmp8("tx flush pulses", 8'h01, 8'(txp));
    cmp1("rx kept", 1'b1, nempty);
    wb(REG_IRQ_MASK, 1'b1, 8'h00);
    flush();
    wb(REG_IRQ_STAT, 1'b1, 8'h07);
    push(13'($urandom()));
    repeat (2) @(posedge sys_clk);
    cmp1("irq masked", 1'b0, irq);
    wb(REG_IRQ_STAT, 1'b0, 8'h00);
    cmp8("irq status", 8'h02, rd);
    wb(REG_IRQ_MASK, 1'b1, 8'h02);
    @(posedge sys_clk);
    cmp1("irq unmasked", 1'b1, irq);
    wb(REG_IRQ_STAT, 1'b1, 8'h02);
    @(posedge sys_clk);
    cmp1("irq cleared", 1'b0, irq);
    $display("test flush and irq done");
    complete_run();
  end
endmodule : rxf_host_tb

// ===== dv/rxf_pump_model.sv
// Purpose: Data pump model that offers bytes with their flags to the receive FIFO
// Assumes: One offer per send pulse, held until the FIFO takes it
// Notes:   Released lines flip to the inverse so a stale byte never passes as fresh
`timescale 1ns/1ps
module rxf_pump_model #(
  parameter int TICK_DIV = 4
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Bench command
  input  wire logic        send,
  input  wire logic [12:0] entry,
  output logic             busy,
  // FIFO side
  input  wire logic        pump_ready,
  output logic             pump_valid,
  output logic [12:0]      pump_word,
  output logic             bit_tick
);
  logic [3:0] div;

  ////////////////////////////////////////
  // Offer stays up until ready; lines flip once released
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pump_valid <= 1'b0;
      pump_word  <= 13'h0000;
    end else if (send) begin
      pump_valid <= 1'b1;
      pump_word  <= entry;
    end else if (pump_valid && pump_ready) begin
      pump_valid <= 1'b0;
      pump_word  <= ~pump_word;
    end
  end

  // Bit time base runs free, like the line rate
  always_ff @(posedge sys_clk) begin
    if (rst || div == 4'(TICK_DIV - 1)) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  assign bit_tick = (div == 4'h0) && !rst;
  assign busy     = pump_valid;
endmodule : rxf_pump_model
